// ---- hw/isdn_card_glue.sv ----
// How it works
// - Both bearer channels and signalling channel share one serial TDM link.
// - Received TDM frames split into three channel streams, each to its own framer.
// - TDM state machine pulses per-channel framer enables at each channel's bit times.
// - Transceiver drives frame sync and bit clock; bearer channels carry eight bits per frame, signalling channel two.
// - Receive framer finds flags, drops stuffed zeros, checks FCS, builds bytes.
// - Voice mode on bearer channels reduces receive framer to serial-to-byte only.
// - Each channel selects a 16-bit or 32-bit CRC as its FCS.
// - Transmit framer serialises, appends FCS, stuffs zeros, and adds flags.
// - Voice mode on bearer channels reduces transmit framer to byte-to-serial only.
// - SRAM, EEPROM and transceiver control port share one eight-bit data bus.
// - Bus ownership is arbitrated so only one device is accessed at once.
// - Each access generates chip select, write and read strobe timing.
// - Memory controller runs on the line-rate clock.
// - Bus time is a round of eight slots of four line clocks.
// - Four slots per round serve host accesses to SRAM, EEPROM or control port.
// - Remaining four slots serve the buffer manager for the six queues.
// - Six fixed 1 KB SRAM queues, one in and one out per channel.
// - Queues are FIFOs reached through three data ports and status registers.
// - Host interface decodes accesses, handshakes, holds config option and status.
// - Framers and TDM logic advance once every eight line clocks.
`default_nettype none
module isdn_card_glue
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [isdn_glue_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // TDM link to the transceiver.
  input wire logic tdm_clk,
  input wire logic tdm_fsync,
  input wire logic tdm_rx,
  output logic tdm_tx,
  // Shared eight-bit memory and control port bus.
  output logic [12:0] bus_addr,
  input wire logic [7:0] bus_din,
  output logic [7:0] bus_dout,
  output logic bus_doe_n,
  output logic sram_ce_n,
  output logic eeprom_ce_n,
  output logic pcp_cs_n,
  output logic bus_we_n,
  output logic bus_oe_n
);
  import isdn_glue_pkg::*;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
                                           input logic w32);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ d[i])
        r = (r >> 1) ^ (w32 ? CRC32_POLY : CRC16_POLY);
      else
        r = r >> 1;
    end
    return r;
  endfunction

  function automatic logic crc_good(input logic [31:0] c, input logic w32);
    return w32 ? (c == CRC32_RES) : (c[15:0] == CRC16_RES);
  endfunction

  logic [4:0] ctrl_r;
  logic [7:0] cor_r, csr_r;
  logic [5:0] fstat_r;
  logic [2:0] div_r;
  logic tick_r, tclk_q_r, rx_bit_r, tdm_tx_r;
  logic [4:0] pos_r, pos_nxt;
  logic [2:0] rx_en_r, tx_en_r, voice_v, c32_v, pos_ch;
  wire [2:0] rx_push, fr_end, fr_bad, tx_take, tx_bit;
  wire [2:0][7:0] rx_byte;
  logic [2:0] rx_pend_r, tx_hold_v_r;
  logic [7:0] rx_dat_r [3];
  logic [7:0] tx_hold_r [3];
  logic [9:0] wp_r [6];
  logic [9:0] rp_r [6];
  logic [10:0] qcnt_r [6];
  logic [5:0] qempty, qfull;

  assign voice_v = {1'b0, ctrl_r[CTRL_VOICE_LSB +: 2]};
  assign c32_v = ctrl_r[CTRL_CRC32_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Slow tick and TDM multiplexer.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= 3'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 3'h1;
      tick_r <= (div_r == DIV_LAST);
    end
  end

  always_comb
  begin
    if (tdm_fsync)
      pos_nxt = 5'h00;
    else if (pos_r >= POS_D_END)
      pos_nxt = POS_IDLE;
    else
      pos_nxt = pos_r + 5'h01;
    if (pos_nxt <= POS_B1_END)
      pos_ch = 3'b001;
    else if (pos_nxt <= POS_B2_END)
      pos_ch = 3'b010;
    else if (pos_nxt <= POS_D_END)
      pos_ch = 3'b100;
    else
      pos_ch = 3'b000;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tclk_q_r <= 1'b0;
      pos_r <= POS_IDLE;
      rx_en_r <= 3'h0;
      tx_en_r <= 3'h0;
      rx_bit_r <= 1'b0;
    end
    else
    begin
      rx_en_r <= 3'h0;
      tx_en_r <= 3'h0;
      if (tick_r)
      begin
        tclk_q_r <= tdm_clk;
        if (tdm_clk && !tclk_q_r)
        begin
          pos_r <= pos_nxt;
          rx_en_r <= pos_ch;
          tx_en_r <= pos_ch;
          rx_bit_r <= tdm_rx;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tdm_tx_r <= 1'b1;
    else if (|tx_en_r)
      tdm_tx_r <= |(tx_bit & tx_en_r);
  end
  assign tdm_tx = tdm_tx_r;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel receive and transmit framers.

  for (genvar c = 0; c < 3; c++)
  begin : g_ch
    logic [7:0] raw_r, sh_r, byte_r, nraw, nsh, tsh_r;
    logic [2:0] cnt_r, ones_r, tcnt_r, tones_r;
    logic infr_r, got_r, push_r, end_r, bad_r, take_r, stuff;
    logic [31:0] crc_r, tcrc_r, init;
    logic [1:0] fleft_r;
    tx_kind_e kind_r;

    assign nraw = {rx_bit_r, raw_r[7:1]};
    assign nsh = {rx_bit_r, sh_r[7:1]};
    assign init = c32_v[c] ? CRC32_INIT : CRC16_INIT;
    assign rx_push[c] = push_r;
    assign rx_byte[c] = byte_r;
    assign fr_end[c] = end_r;
    assign fr_bad[c] = bad_r;

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        raw_r <= 8'h00;
        sh_r <= 8'h00;
        byte_r <= 8'h00;
        cnt_r <= 3'h0;
        ones_r <= 3'h0;
        infr_r <= 1'b0;
        got_r <= 1'b0;
        push_r <= 1'b0;
        end_r <= 1'b0;
        bad_r <= 1'b0;
        crc_r <= CRC32_INIT;
      end
      else
      begin
        push_r <= 1'b0;
        end_r <= 1'b0;
        bad_r <= 1'b0;
        if (rx_en_r[c])
        begin
          raw_r <= nraw;
          if (voice_v[c])
          begin
            sh_r <= nsh;
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7)
            begin
              push_r <= 1'b1;
              byte_r <= nsh;
            end
          end
          else if (nraw == HDLC_FLAG)
          begin
            if (infr_r && got_r)
            begin
              end_r <= 1'b1;
              bad_r <= !crc_good(crc_r, c32_v[c]);
            end
            infr_r <= 1'b1;
            got_r <= 1'b0;
            cnt_r <= 3'h0;
            ones_r <= 3'h0;
            crc_r <= init;
          end
          else if (ones_r == ABORT_ONES && rx_bit_r)
            infr_r <= 1'b0;
          else if (ones_r == STUFF_ONES && !rx_bit_r)
            ones_r <= 3'h0;
          else
          begin
            ones_r <= rx_bit_r ? ones_r + 3'h1 : 3'h0;
            if (infr_r)
            begin
              sh_r <= nsh;
              cnt_r <= cnt_r + 3'h1;
              if (cnt_r == 3'h7)
              begin
                push_r <= 1'b1;
                byte_r <= nsh;
                got_r <= 1'b1;
                crc_r <= crc_byte(crc_r, nsh, c32_v[c]);
              end
            end
          end
        end
      end
    end

    assign stuff = !voice_v[c] && kind_r != TXK_FLAG && tones_r == STUFF_ONES;
    assign tx_bit[c] = stuff ? 1'b0 : tsh_r[0];
    assign tx_take[c] = take_r;

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        tsh_r <= HDLC_FLAG;
        tcnt_r <= 3'h0;
        tones_r <= 3'h0;
        kind_r <= TXK_FLAG;
        tcrc_r <= CRC32_INIT;
        fleft_r <= 2'h0;
        take_r <= 1'b0;
      end
      else
      begin
        take_r <= 1'b0;
        if (tx_en_r[c])
        begin
          if (stuff)
            tones_r <= 3'h0;
          else
          begin
            tsh_r <= {1'b0, tsh_r[7:1]};
            tones_r <= (kind_r != TXK_FLAG && tsh_r[0]) ? tones_r + 3'h1 : 3'h0;
            tcnt_r <= tcnt_r + 3'h1;
            if (tcnt_r == 3'h7)
            begin
              if (voice_v[c])
              begin
                tsh_r <= tx_hold_v_r[c] ? tx_hold_r[c] : IDLE_BYTE;
                take_r <= tx_hold_v_r[c];
                kind_r <= TXK_DATA;
              end
              else if (tx_hold_v_r[c] && kind_r != TXK_FCS)
              begin
                tsh_r <= tx_hold_r[c];
                take_r <= 1'b1;
                kind_r <= TXK_DATA;
                tcrc_r <= crc_byte(kind_r == TXK_FLAG ? init : tcrc_r, tx_hold_r[c],
                                   c32_v[c]);
              end
              else if (kind_r == TXK_DATA)
              begin
                tsh_r <= ~tcrc_r[7:0];
                tcrc_r <= ~tcrc_r >> 8;
                fleft_r <= c32_v[c] ? 2'h3 : 2'h1;
                kind_r <= TXK_FCS;
              end
              else if (kind_r == TXK_FCS && fleft_r != 2'h0)
              begin
                tsh_r <= tcrc_r[7:0];
                tcrc_r <= tcrc_r >> 8;
                fleft_r <= fleft_r - 2'h1;
              end
              else
              begin
                tsh_r <= HDLC_FLAG;
                kind_r <= TXK_FLAG;
              end
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot sequencer, arbitration and bus strobes.

  logic [2:0] slot_r, qsel_r, op_q_r, hp_q_r;
  logic [1:0] cyc_r;
  logic op_v_r, op_we_r, op_host_r, op_qop_r, done;
  logic [12:0] op_addr_r, hp_addr_r;
  logic [7:0] op_wd_r, hp_wd_r;
  op_kind_e op_kind_r, hp_kind_r;
  logic hp_r, hp_we_r, hp_isq_r;

  assign done = op_v_r && cyc_r == SLOT_LAST;

  always_comb
  begin
    for (int q = 0; q < 6; q++)
    begin
      qempty[q] = (qcnt_r[q] == 11'h000);
      qfull[q] = (qcnt_r[q] == QFULL);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cyc_r <= 2'h0;
      slot_r <= 3'h0;
    end
    else
    begin
      cyc_r <= cyc_r + 2'h1;
      if (cyc_r == SLOT_LAST)
        slot_r <= slot_r + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      op_v_r <= 1'b0;
      op_we_r <= 1'b0;
      op_host_r <= 1'b0;
      op_qop_r <= 1'b0;
      op_q_r <= 3'h0;
      op_addr_r <= 13'h0000;
      op_wd_r <= 8'h00;
      op_kind_r <= OP_SRAM;
      qsel_r <= 3'h0;
    end
    else if (cyc_r == 2'h0)
    begin
      if (!slot_r[0])
      begin
        op_v_r <= hp_r;
        op_host_r <= 1'b1;
        op_kind_r <= hp_kind_r;
        op_we_r <= hp_we_r;
        op_wd_r <= hp_wd_r;
        op_q_r <= hp_q_r;
        op_qop_r <= hp_isq_r;
        op_addr_r <= hp_isq_r ? {hp_q_r, hp_q_r[0] ? wp_r[hp_q_r] : rp_r[hp_q_r]} : hp_addr_r;
      end
      else
      begin
        op_host_r <= 1'b0;
        op_kind_r <= OP_SRAM;
        op_qop_r <= 1'b1;
        op_q_r <= qsel_r;
        qsel_r <= (qsel_r == NQ_LAST) ? 3'h0 : qsel_r + 3'h1;
        op_we_r <= !qsel_r[0];
        op_wd_r <= rx_dat_r[qsel_r[2:1]];
        if (!qsel_r[0])
        begin
          op_v_r <= rx_pend_r[qsel_r[2:1]] && !qfull[qsel_r];
          op_addr_r <= {qsel_r, wp_r[qsel_r]};
        end
        else
        begin
          op_v_r <= !tx_hold_v_r[qsel_r[2:1]] && !qempty[qsel_r];
          op_addr_r <= {qsel_r, rp_r[qsel_r]};
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_addr <= 13'h0000;
      bus_dout <= 8'h00;
      bus_doe_n <= 1'b1;
      sram_ce_n <= 1'b1;
      eeprom_ce_n <= 1'b1;
      pcp_cs_n <= 1'b1;
      bus_we_n <= 1'b1;
      bus_oe_n <= 1'b1;
    end
    else if (cyc_r == 2'h1 && op_v_r)
    begin
      bus_addr <= op_addr_r;
      bus_dout <= op_wd_r;
      bus_doe_n <= !op_we_r;
      sram_ce_n <= op_kind_r != OP_SRAM;
      eeprom_ce_n <= op_kind_r != OP_EEPROM;
      pcp_cs_n <= op_kind_r != OP_PCP;
    end
    else if (cyc_r == 2'h2 && op_v_r)
    begin
      bus_we_n <= !op_we_r;
      bus_oe_n <= op_we_r;
    end
    else if (cyc_r == SLOT_LAST)
    begin
      bus_doe_n <= 1'b1;
      sram_ce_n <= 1'b1;
      eeprom_ce_n <= 1'b1;
      pcp_cs_n <= 1'b1;
      bus_we_n <= 1'b1;
      bus_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer manager: queue pointers and framer hand-off bytes.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int q = 0; q < 6; q++)
      begin
        wp_r[q] <= 10'h000;
        rp_r[q] <= 10'h000;
        qcnt_r[q] <= 11'h000;
      end
    end
    else if (done && op_qop_r && op_kind_r == OP_SRAM)
    begin
      if (op_we_r)
      begin
        wp_r[op_q_r] <= wp_r[op_q_r] + 10'h001;
        qcnt_r[op_q_r] <= qcnt_r[op_q_r] + 11'h001;
      end
      else
      begin
        rp_r[op_q_r] <= rp_r[op_q_r] + 10'h001;
        qcnt_r[op_q_r] <= qcnt_r[op_q_r] - 11'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_pend_r <= 3'h0;
      tx_hold_v_r <= 3'h0;
      for (int c = 0; c < 3; c++)
      begin
        rx_dat_r[c] <= 8'h00;
        tx_hold_r[c] <= 8'h00;
      end
    end
    else
    begin
      for (int c = 0; c < 3; c++)
      begin
        if (rx_push[c])
        begin
          rx_pend_r[c] <= 1'b1;
          rx_dat_r[c] <= rx_byte[c];
        end
        else if (done && !op_host_r && op_we_r && op_q_r[2:1] == c[1:0])
          rx_pend_r[c] <= 1'b0;
        if (done && !op_host_r && !op_we_r && op_q_r[2:1] == c[1:0])
        begin
          tx_hold_v_r[c] <= 1'b1;
          tx_hold_r[c] <= bus_din;
        end
        else if (tx_take[c])
          tx_hold_v_r[c] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host interface.

  logic acc, is_ee, is_pcp, is_dq, dq_ok, need_bus, wait_r;
  logic [1:0] dq_ch;
  logic [2:0] dq_q;
  logic [31:0] reg_rd, rdata_r;

  always_comb
  begin
    acc = (avs_read || avs_write) && wait_r && !hp_r;
    is_ee = avs_address[EE_SEL_BIT];
    is_pcp = avs_address[13:6] == PCP_PAGE;
    is_dq = avs_address == OFS_DATA0 || avs_address == OFS_DATA1 || avs_address == OFS_DATA2;
    dq_ch = avs_address[3:2];
    dq_q = {dq_ch, avs_write};
    dq_ok = avs_write ? !qfull[dq_q] : !qempty[dq_q];
    need_bus = is_ee || is_pcp || (is_dq && dq_ok);
    case (avs_address)
      OFS_QSTAT: reg_rd = {18'h00000, qfull, 2'h0, qempty};
      OFS_CTRL: reg_rd = {27'h0000000, ctrl_r};
      OFS_COR: reg_rd = {24'h000000, cor_r};
      OFS_CSR: reg_rd = {24'h000000, csr_r};
      OFS_FSTAT: reg_rd = {26'h0000000, fstat_r};
      default: reg_rd = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      hp_r <= 1'b0;
      hp_we_r <= 1'b0;
      hp_isq_r <= 1'b0;
      hp_q_r <= 3'h0;
      hp_addr_r <= 13'h0000;
      hp_wd_r <= 8'h00;
      hp_kind_r <= OP_SRAM;
    end
    else
    begin
      wait_r <= 1'b1;
      if (done && op_host_r)
      begin
        wait_r <= 1'b0;
        hp_r <= 1'b0;
        rdata_r <= op_we_r ? 32'h00000000 : {24'h000000, bus_din};
      end
      else if (acc && need_bus)
      begin
        hp_r <= 1'b1;
        hp_we_r <= avs_write;
        hp_wd_r <= avs_writedata[7:0];
        hp_isq_r <= is_dq && !is_ee && !is_pcp;
        hp_q_r <= dq_q;
        hp_kind_r <= is_ee ? OP_EEPROM : (is_pcp ? OP_PCP : OP_SRAM);
        hp_addr_r <= is_ee ? {2'h0, avs_address[12:2]} : {9'h000, avs_address[5:2]};
      end
      else if (acc)
      begin
        wait_r <= 1'b0;
        rdata_r <= avs_read ? reg_rd : 32'h00000000;
      end
    end
  end
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= CTRL_RST;
      cor_r <= COR_RST;
      csr_r <= CSR_RST;
      fstat_r <= 6'h00;
    end
    else
    begin
      if (acc && !need_bus && avs_write && avs_address == OFS_CTRL)
        ctrl_r <= avs_writedata[4:0];
      if (acc && !need_bus && avs_write && avs_address == OFS_COR)
        cor_r <= avs_writedata[7:0];
      if (acc && !need_bus && avs_write && avs_address == OFS_CSR)
        csr_r <= avs_writedata[7:0];
      if (acc && !need_bus && avs_write && avs_address == OFS_FSTAT)
        fstat_r <= (fstat_r & ~avs_writedata[5:0]) | {fr_bad, fr_end};
      else
        fstat_r <= fstat_r | {fr_bad, fr_end};
    end
  end
endmodule
`default_nettype wire

// ---- hw/isdn_glue_pkg.sv ----
`default_nettype none
package isdn_glue_pkg;
  // Register bus geometry.
  localparam int AW = 14;
  localparam logic [13:0] OFS_DATA0 = 14'h0000;
  localparam logic [13:0] OFS_DATA1 = 14'h0004;
  localparam logic [13:0] OFS_DATA2 = 14'h0008;
  localparam logic [13:0] OFS_QSTAT = 14'h000C;
  localparam logic [13:0] OFS_CTRL = 14'h0010;
  localparam logic [13:0] OFS_COR = 14'h0014;
  localparam logic [13:0] OFS_CSR = 14'h0018;
  localparam logic [13:0] OFS_FSTAT = 14'h001C;
  localparam logic [7:0] PCP_PAGE = 8'h04;
  localparam int EE_SEL_BIT = 13;
  // Control register fields.
  localparam int CTRL_VOICE_LSB = 0;
  localparam int CTRL_CRC32_LSB = 2;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [7:0] COR_RST = 8'h00;
  localparam logic [7:0] CSR_RST = 8'h00;
  // Timing: one slow tick per eight line clocks, four line clocks per bus slot.
  localparam logic [2:0] DIV_LAST = 3'h7;
  localparam logic [1:0] SLOT_LAST = 2'h3;
  localparam logic [2:0] NQ_LAST = 3'h5;
  // Queues: 1 KB each in SRAM.
  localparam logic [10:0] QFULL = 11'h400;
  // TDM frame positions in bit clocks after frame sync.
  localparam logic [4:0] POS_B1_END = 5'h07;
  localparam logic [4:0] POS_B2_END = 5'h0F;
  localparam logic [4:0] POS_D_END = 5'h11;
  localparam logic [4:0] POS_IDLE = 5'h1F;
  // HDLC constants.
  localparam logic [7:0] HDLC_FLAG = 8'h7E;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [2:0] ABORT_ONES = 3'h6;
  localparam logic [31:0] CRC16_POLY = 32'h00008408;
  localparam logic [31:0] CRC32_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC16_INIT = 32'h0000FFFF;
  localparam logic [31:0] CRC32_INIT = 32'hFFFFFFFF;
  localparam logic [15:0] CRC16_RES = 16'hF0B8;
  localparam logic [31:0] CRC32_RES = 32'hDEBB20E3;
  typedef enum logic [1:0] {OP_SRAM, OP_EEPROM, OP_PCP} op_kind_e;
  typedef enum logic [1:0] {TXK_FLAG, TXK_DATA, TXK_FCS} tx_kind_e;
endpackage
`default_nettype wire

// ---- tb/isdn_card_glue_assertions.sv ----
`default_nettype none
module isdn_card_glue_assertions
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register bus handshake.
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Shared bus controls.
  input wire logic bus_doe_n,
  input wire logic sram_ce_n,
  input wire logic eeprom_ce_n,
  input wire logic pcp_cs_n,
  input wire logic bus_we_n,
  input wire logic bus_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [2:0] sel = ~{sram_ce_n, eeprom_ce_n, pcp_cs_n};
  wire logic any_sel = |sel;
  wire logic strobe = ~bus_we_n | ~bus_oe_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  chk_one_select: assert property ($onehot0(sel))
    else $error("two bus devices selected together");
  chk_strobe_excl: assert property (!(!bus_we_n && !bus_oe_n))
    else $error("write and read strobes low together");
  chk_strobe_sel: assert property (strobe |-> any_sel)
    else $error("strobe without a device select");
  chk_sel_then_strobe: assert property ($rose(any_sel) |=> strobe ##1 !any_sel)
    else $error("slot access timing wrong");
  chk_strobe_pulse: assert property ($rose(strobe) |=> !strobe)
    else $error("strobe longer than one cycle");
  chk_slot_gap: assert property ($rose(any_sel) |=> !$rose(any_sel) [*3])
    else $error("two accesses inside one slot");
  chk_drive_write: assert property (!bus_doe_n |-> bus_oe_n)
    else $error("bus driven during a read");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_host_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[0:40] !avs_waitrequest)
    else $error("host request not answered within a round");
  cover property ($rose(!eeprom_ce_n));
  cover property ($rose(!pcp_cs_n));
  cover property ($rose(!sram_ce_n));
  cover property ($rose(!bus_we_n));
endmodule
`default_nettype wire

// ---- tb/isdn_far_side.sv ----
`default_nettype none
module isdn_far_side
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Shared bus.
  input wire logic [12:0] bus_addr,
  input wire logic [7:0] bus_dout,
  input wire logic bus_doe_n,
  input wire logic sram_ce_n,
  input wire logic eeprom_ce_n,
  input wire logic pcp_cs_n,
  input wire logic bus_we_n,
  input wire logic bus_oe_n,
  output logic [7:0] bus_din,
  // TDM link.
  input wire logic tdm_tx,
  output logic tdm_clk,
  output logic tdm_fsync,
  output logic tdm_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sram [0:8191];
  logic [7:0] ee [0:2047];
  logic [7:0] transceiver_parallel_control_port [0:255];
  logic [7:0] rd, last;
  logic [31:0] frame;
  logic [4:0] cnt, pos;
  always_comb rd = !sram_ce_n ? sram[bus_addr] :
    (!eeprom_ce_n ? ee[bus_addr[10:0]] : transceiver_parallel_control_port[bus_addr[7:0]]);
  // A released bus shows the inverse of the last value so stale data never matches.
  assign bus_din = !bus_oe_n ? rd : ~last;
  always @(posedge clk)
  begin
    if (!bus_oe_n)
      last <= rd;
    if (!bus_we_n && !bus_doe_n && !sram_ce_n)
      sram[bus_addr] <= bus_dout;
    if (!bus_we_n && !bus_doe_n && !eeprom_ce_n)
      ee[bus_addr[10:0]] <= bus_dout;
    if (!bus_we_n && !bus_doe_n && !pcp_cs_n)
      transceiver_parallel_control_port[bus_addr[7:0]] <= bus_dout;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Line side loops each frame back one frame later at the same bit positions.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 5'h00;
      pos <= 5'h1F;
      tdm_clk <= 1'b0;
      tdm_fsync <= 1'b0;
      tdm_rx <= 1'b1;
      frame <= 32'hFFFFFFFF;
    end
    else
    begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'h0F)
      begin
        tdm_clk <= 1'b0;
        tdm_rx <= frame[pos + 5'h01];
        tdm_fsync <= (pos == 5'h1F);
      end
      if (cnt == 5'h1F)
      begin
        tdm_clk <= 1'b1;
        pos <= pos + 5'h01;
        frame[pos] <= tdm_tx;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_isdn_card_glue.sv ----
`default_nettype none
module test_isdn_card_glue;
  timeunit 1ns;
  timeprecision 1ps;
  import isdn_glue_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [AW-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rv;
  logic avs_waitrequest, tdm_clk, tdm_fsync, tdm_rx, tdm_tx;
  logic [12:0] bus_addr;
  logic [7:0] bus_din, bus_dout;
  logic bus_doe_n, sram_ce_n, eeprom_ce_n, pcp_cs_n, bus_we_n, bus_oe_n;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  isdn_card_glue i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .tdm_clk, .tdm_fsync, .tdm_rx, .tdm_tx, .bus_addr,
    .bus_din, .bus_dout, .bus_doe_n, .sram_ce_n, .eeprom_ce_n, .pcp_cs_n, .bus_we_n, .bus_oe_n);
  isdn_far_side i_far (.clk, .rst, .bus_addr, .bus_dout, .bus_doe_n, .sram_ce_n, .eeprom_ce_n,
    .pcp_cs_n, .bus_we_n, .bus_oe_n, .bus_din, .tdm_tx, .tdm_clk, .tdm_fsync, .tdm_rx);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("TB: errors %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // The request stands until waitrequest is seen low; only the cycle limit ends a hang.
  task automatic acc(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  // Sends two bytes as one frame on the first bearer, waits for the loopback, then drains
  // the stored FCS bytes so that the FCS length is checked through the empty flags.
  task automatic frame_chk(input logic [31:0] ctrl, input int nfcs);
    acc(1'b1, OFS_CTRL, ctrl);
    acc(1'b1, OFS_DATA0, 32'h00000011);
    acc(1'b1, OFS_DATA0, 32'h00000022);
    rv = 32'h0;
    for (int i = 0; i < 80 && !rv[0]; i++)
    begin
      repeat (200) @(posedge clk);
      acc(1'b0, OFS_FSTAT, 32'h0);
    end
    chk(32'(rv[0]), 32'h1);
    chk(32'(rv[3]), 32'h0);
    acc(1'b1, OFS_FSTAT, 32'h0000003F);
    rd_chk(OFS_FSTAT, 32'h0);
    rd_chk(OFS_DATA0, 32'h00000011);
    rd_chk(OFS_DATA0, 32'h00000022);
    acc(1'b0, OFS_QSTAT, 32'h0);
    chk(32'(rv[1]), 32'h1);
    chk(32'(rv[9]), 32'h0);
    chk(32'(rv[0]), 32'h0);
    for (int i = 0; i < nfcs; i++)
      acc(1'b0, OFS_DATA0, 32'h0);
    rd_chk(OFS_QSTAT, 32'h0000003F);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_CTRL, 32'(CTRL_RST));
    rd_chk(OFS_QSTAT, 32'h0000003F);
    rd_chk(OFS_COR, 32'(COR_RST));
    rd_chk(OFS_CSR, 32'(CSR_RST));
    rd_chk(14'h0020, 32'h0);
    acc(1'b1, OFS_COR, 32'h000001A5);
    acc(1'b1, OFS_CSR, 32'h0000003C);
    rd_chk(OFS_COR, 32'h000000A5);
    rd_chk(OFS_CSR, 32'h0000003C);
    acc(1'b1, OFS_CTRL, 32'h000000FF);
    rd_chk(OFS_CTRL, 32'h0000001F);
    acc(1'b1, OFS_CTRL, 32'h0);
    rd_chk(OFS_DATA0, 32'h0);
    acc(1'b1, 14'h2014, 32'h0000005A);
    rd_chk(14'h2014, 32'h0000005A);
    chk(32'(i_far.ee[5]), 32'h0000005A);
    acc(1'b1, 14'h0104, 32'h000000C3);
    rd_chk(14'h0104, 32'h000000C3);
    frame_chk(32'h0, 2);
    frame_chk(32'h00000004, 4);
    final_report();
  end
endmodule
bind isdn_card_glue isdn_card_glue_assertions i_chk (.clk, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .bus_doe_n, .sram_ce_n, .eeprom_ce_n, .pcp_cs_n, .bus_we_n, .bus_oe_n);
`default_nettype wire
